// >>> hw/hpi_pkg.sv
// hpi_pkg: constants, register map and types shared by the hub port power
// and indicator block.
// assumes a single 40 MHz clock and the plain strobe register port.
package hpi_pkg;

   localparam int NUM_PORTS = 4;

   // register byte addresses, one 32-bit word each
   localparam logic [7:0] OFS_CONFIG  = 8'h00;
   localparam logic [7:0] OFS_OC_TIME = 8'h04;
   localparam logic [7:0] OFS_POWER   = 8'h08;
   localparam logic [7:0] OFS_IND     = 8'h0c;
   localparam logic [7:0] OFS_STATUS  = 8'h10;

   // configuration word, bit 0 is ganged
   typedef struct packed {
      logic modulate;     // bit 5: square-wave the lamps
      logic ind_present;  // bit 4: descriptor advertises indicators
      logic led_hi;       // bit 3: lamp outputs active high
      logic oc_hi;        // bit 2: overcurrent sense active high
      logic pwr_hi;       // bit 1: power enable active high
      logic ganged;       // bit 0: ganged switching
   } hpi_cfg_type;
   localparam int          CFG_W     = 6;
   localparam logic [5:0]  CFG_RESET = 6'h10;

   // overcurrent filter times in ms, enabled ports and disabled ports
   localparam int          MS_W           = 4;
   localparam int          OC_ENA_LSB     = 0;
   localparam int          OC_DIS_LSB     = 4;
   localparam logic [3:0]  OC_MS_DEFAULT  = 4'h8;

   // power and status register fields
   localparam int PWR_SET_LSB = 0;
   localparam int PWR_CLR_LSB = 4;
   localparam int EN_RD_LSB   = 4;
   localparam int STAT_LIVE_LSB = 4;

   // indicator selectors, three bits per port
   localparam int         IND_CODE_W     = 3;
   localparam logic [2:0] IND_AUTO       = 3'h0;
   localparam logic [2:0] IND_AMBER      = 3'h1;
   localparam logic [2:0] IND_GREEN      = 3'h2;
   localparam logic [2:0] IND_OFF        = 3'h3;
   localparam logic [2:0] IND_BLINK_G    = 3'h4;
   localparam logic [2:0] IND_BLINK_A    = 3'h5;
   localparam logic [2:0] IND_BLINK_GA   = 3'h6;

   // timing
   localparam int CLK_PERIOD_NS  = 25;
   localparam int MS_NS          = 1000000;
   localparam int MS_CYCLES_DEF  = MS_NS / CLK_PERIOD_NS;
   localparam int MS_CNT_W       = 16;
   localparam int BLINK_HALF_MS  = 500;
   localparam int BLINK_W        = 9;
   localparam int MOD_DIV_W      = 3;

   // per-port power state, one-hot
   typedef enum logic [3:0] {
      PS_OFF = 4'h1,
      PS_ON  = 4'h2,
      PS_EN  = 4'h4,
      PS_OC  = 4'h8
   } hpi_port_state_type;

   // register port request
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } hpi_bus_type;

endpackage : hpi_pkg

// >>> hw/hpi_oc_filter.sv
// hpi_oc_filter: time filter for one overcurrent sense input.
// assumes the sense input is synchronous and a one-cycle ms tick.
`timescale 1ns/1ps
`default_nettype none
module hpi_oc_filter
   import hpi_pkg::*;
(
   input  wire logic             clock_i,
   input  wire logic             reset_i,
   input  wire logic             sense_i,
   input  wire logic             active_hi_i,
   input  wire logic [MS_W-1:0]  limit_ms_i,
   input  wire logic             ms_tick_i,
   output var  logic             trip_o
);

   logic            active;
   logic [MS_W-1:0] count;

   assign active = sense_i ~^ active_hi_i;

   // count whole ms while active; one idle sample restarts the count
   always_ff @(posedge clock_i or posedge reset_i)
   begin
      if (reset_i)
         count <= '0;
      else if (!active)
         count <= '0;
      else if (ms_tick_i && count != limit_ms_i && count != '1)
         count <= count + 4'h1;
   end

   // a zero limit trips on the first active sample
   always_ff @(posedge clock_i or posedge reset_i)
   begin
      if (reset_i)
         trip_o <= 1'b0;
      else
         trip_o <= active && (count >= limit_ms_i);
   end

   property p_filter_restart;
      @(posedge clock_i) disable iff (reset_i)
      !active |=> (count == '0) && !trip_o;
   endproperty
   a_filter_restart: assert property (p_filter_restart)
      else $error("overcurrent filter did not restart");

endmodule : hpi_oc_filter
`default_nettype wire

// >>> hw/hpi_lamp.sv
// hpi_lamp: green and amber lamp drive for one port.
// assumes blink and modulation phases come from shared dividers.
`timescale 1ns/1ps
`default_nettype none
module hpi_lamp
   import hpi_pkg::*;
(
   input  wire logic                  clock_i,
   input  wire logic                  reset_i,
   input  wire logic [IND_CODE_W-1:0] code_i,
   input  wire logic                  auto_green_i,
   input  wire logic                  auto_amber_i,
   input  wire logic                  blink_i,
   input  wire logic                  mod_phase_i,
   input  wire hpi_cfg_type           cfg_i,
   output var  logic                  green_o,
   output var  logic                  amber_o
);

   logic lit_g;
   logic lit_a;

   // selector decode; the reserved pair stays dark
   always_comb
   begin
      lit_g = 1'b0;
      lit_a = 1'b0;
      case (code_i)
         IND_AUTO:    begin lit_g = auto_green_i; lit_a = auto_amber_i; end
         IND_AMBER:   lit_a = 1'b1;
         IND_GREEN:   lit_g = 1'b1;
         IND_BLINK_G: lit_g = blink_i;
         IND_BLINK_A: lit_a = blink_i;
         default:     begin lit_g = 1'b0; lit_a = 1'b0; end
      endcase
      if (!cfg_i.ind_present)
      begin
         lit_g = 1'b0;
         lit_a = 1'b0;
      end
   end

   // modulation and polarity, registered so the pins never glitch
   always_ff @(posedge clock_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         green_o <= 1'b1;
         amber_o <= 1'b1;
      end
      else
      begin
         green_o <= (lit_g && (!cfg_i.modulate || mod_phase_i)) ~^ cfg_i.led_hi;
         amber_o <= (lit_a && (!cfg_i.modulate || mod_phase_i)) ~^ cfg_i.led_hi;
      end
   end

   property p_manual_off;
      @(posedge clock_i) disable iff (reset_i)
      (code_i == IND_OFF) ##1 $stable(cfg_i) |-> (green_o == !cfg_i.led_hi);
   endproperty
   a_manual_off: assert property (p_manual_off)
      else $error("manual off code lit the green lamp");

endmodule : hpi_lamp
`default_nettype wire

// >>> hw/hpi_port_power.sv
// hpi_port_power: downstream port power switching, overcurrent handling
// and port indicators for a four-port hub.
// assumes the hub core decodes class requests into register writes and
// supplies per-port connect, reset-done, disable and transmit levels.
`timescale 1ns/1ps
`default_nettype none

module hpi_port_power
   import hpi_pkg::*;
#(
   parameter int unsigned MS_CYCLES = MS_CYCLES_DEF
)
(
   input  wire logic                 clock_i,
   input  wire logic                 reset_i,
   input  wire hpi_bus_type          bus_i,
   output var  logic [31:0]          rdata_o,
   input  wire logic                 hub_configured_i,
   input  wire logic [NUM_PORTS-1:0] port_connected_i,
   input  wire logic [NUM_PORTS-1:0] port_reset_done_i,
   input  wire logic [NUM_PORTS-1:0] port_disable_i,
   input  wire logic [NUM_PORTS-1:0] port_transmit_i,
   input  wire logic [NUM_PORTS-1:0] port_overcurrent_sense_n_i,
   output var  logic [NUM_PORTS-1:0] port_power_enable_n_o,
   output var  logic [NUM_PORTS-1:0] port_enabled_o,
   output var  logic                 oc_report_o,
   output var  logic                 hub_char_indicator_o,
   output var  logic [NUM_PORTS-1:0] led_green_o,
   output var  logic [NUM_PORTS-1:0] led_amber_o
);

   hpi_cfg_type                      cfg;
   logic [MS_W-1:0]                  ms_enabled;
   logic [MS_W-1:0]                  ms_disabled;
   logic [NUM_PORTS*IND_CODE_W-1:0]  ind_code;
   logic [NUM_PORTS-1:0]             oc_event;
   logic [NUM_PORTS-1:0]             filt;
   logic [NUM_PORTS-1:0]             trip_eff;
   logic [NUM_PORTS-1:0]             pwr_on_req;
   logic [NUM_PORTS-1:0]             pwr_off_req;
   logic [NUM_PORTS-1:0]             powered;
   logic [NUM_PORTS-1:0]             enabled;
   logic [NUM_PORTS-1:0]             off_by_oc;
   logic [MS_CNT_W-1:0]              ms_cnt;
   logic                             ms_tick;
   logic [BLINK_W-1:0]               blink_cnt;
   logic                             blink;
   logic [MOD_DIV_W-1:0]             mod_div;
   logic                             wr_power;
   logic                             wr_status;
   hpi_port_state_type               state [NUM_PORTS];

   assign wr_power  = bus_i.wr && (bus_i.addr == OFS_POWER);
   assign wr_status = bus_i.wr && (bus_i.addr == OFS_STATUS);

   // configuration word: loader or software writes it once after reset
   always_ff @(posedge clock_i or posedge reset_i)
   begin
      if (reset_i)
         cfg <= hpi_cfg_type'(CFG_RESET);
      else if (bus_i.wr && bus_i.addr == OFS_CONFIG)
         cfg <= hpi_cfg_type'(bus_i.wdata[CFG_W-1:0]);
   end

   // filter lengths, separate for enabled and disabled ports
   always_ff @(posedge clock_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         ms_enabled  <= OC_MS_DEFAULT;
         ms_disabled <= OC_MS_DEFAULT;
      end
      else if (bus_i.wr && bus_i.addr == OFS_OC_TIME)
      begin
         ms_enabled  <= bus_i.wdata[OC_ENA_LSB +: MS_W];
         ms_disabled <= bus_i.wdata[OC_DIS_LSB +: MS_W];
      end
   end

   // indicator selectors; zero after reset means automatic for every port
   always_ff @(posedge clock_i or posedge reset_i)
   begin
      if (reset_i)
         ind_code <= '0;
      else if (bus_i.wr && bus_i.addr == OFS_IND)
         ind_code <= bus_i.wdata[NUM_PORTS*IND_CODE_W-1:0];
   end

   // sticky overcurrent events; a new trip beats a clear in the same cycle
   always_ff @(posedge clock_i or posedge reset_i)
   begin
      if (reset_i)
         oc_event <= '0;
      else if (wr_status)
         oc_event <= (oc_event & ~bus_i.wdata[NUM_PORTS-1:0]) | filt;
      else
         oc_event <= oc_event | filt;
   end

   // host reporting level and descriptor bit
   always_ff @(posedge clock_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         oc_report_o          <= 1'b0;
         hub_char_indicator_o <= 1'b1;
      end
      else
      begin
         oc_report_o          <= |oc_event;
         hub_char_indicator_o <= cfg.ind_present;
      end
   end

   // read data stand for exactly the cycle after the read strobe
   always_ff @(posedge clock_i or posedge reset_i)
   begin
      if (reset_i)
         rdata_o <= '0;
      else if (!bus_i.rd)
         rdata_o <= '0;
      else
      begin
         case (bus_i.addr)
            OFS_CONFIG:  rdata_o <= {26'h0, cfg};
            OFS_OC_TIME: rdata_o <= {24'h0, ms_disabled, ms_enabled};
            OFS_POWER:   rdata_o <= {24'h0, enabled, powered};
            OFS_IND:     rdata_o <= {20'h0, ind_code};
            OFS_STATUS:  rdata_o <= {24'h0, filt, oc_event};
            default:     rdata_o <= '0;
         endcase
      end
   end

   // millisecond tick for the filters and the blink divider
   always_ff @(posedge clock_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         ms_cnt  <= '0;
         ms_tick <= 1'b0;
      end
      else if (ms_cnt == MS_CNT_W'(MS_CYCLES - 1))
      begin
         ms_cnt  <= '0;
         ms_tick <= 1'b1;
      end
      else
      begin
         ms_cnt  <= ms_cnt + 16'h1;
         ms_tick <= 1'b0;
      end
   end

   // blink phase only reaches lamps through manual blink selectors
   always_ff @(posedge clock_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         blink_cnt <= '0;
         blink     <= 1'b0;
      end
      else if (ms_tick && blink_cnt == BLINK_W'(BLINK_HALF_MS - 1))
      begin
         blink_cnt <= '0;
         blink     <= ~blink;
      end
      else if (ms_tick)
         blink_cnt <= blink_cnt + 9'h1;
   end

   // modulation square wave; fast enough that the eye sees a steady lamp
   always_ff @(posedge clock_i or posedge reset_i)
   begin
      if (reset_i)
         mod_div <= '0;
      else
         mod_div <= mod_div + 3'h1;
   end

   // in ganged mode every port follows any request and any trip
   always_comb
   begin
      for (int k = 0; k < NUM_PORTS; k++)
      begin
         trip_eff[k]    = cfg.ganged ? |filt : filt[k];
         pwr_on_req[k]  = wr_power && hub_configured_i &&
            (cfg.ganged ? |bus_i.wdata[PWR_SET_LSB +: NUM_PORTS]
                        : bus_i.wdata[PWR_SET_LSB + k]);
         pwr_off_req[k] = wr_power &&
            (cfg.ganged ? |bus_i.wdata[PWR_CLR_LSB +: NUM_PORTS]
                        : bus_i.wdata[PWR_CLR_LSB + k]);
      end
   end

   genvar i;
   generate
      for (i = 0; i < NUM_PORTS; i++)
      begin : g_port
         // enabled ports use their own filter length
         hpi_oc_filter u_filter (
            .clock_i     (clock_i),
            .reset_i     (reset_i),
            .sense_i     (port_overcurrent_sense_n_i[i]),
            .active_hi_i (cfg.oc_hi),
            .limit_ms_i  (enabled[i] ? ms_enabled : ms_disabled),
            .ms_tick_i   (ms_tick),
            .trip_o      (filt[i])
         );

         // port power state; a trip outranks every request
         always_ff @(posedge clock_i or posedge reset_i)
         begin
            if (reset_i)
               state[i] <= PS_OFF;
            else
            begin
               case (state[i])
                  PS_OFF, PS_OC:
                     if (pwr_on_req[i] && !pwr_off_req[i] && !trip_eff[i])
                        state[i] <= PS_ON;
                  PS_ON:
                     if (trip_eff[i])
                        state[i] <= PS_OC;
                     else if (pwr_off_req[i])
                        state[i] <= PS_OFF;
                     else if (port_reset_done_i[i] && port_connected_i[i])
                        state[i] <= PS_EN;
                  PS_EN:
                     if (trip_eff[i])
                        state[i] <= PS_OC;
                     else if (pwr_off_req[i])
                        state[i] <= PS_OFF;
                     else if (port_disable_i[i] || !port_connected_i[i])
                        state[i] <= PS_ON;
                  default:
                     state[i] <= PS_OFF;
               endcase
            end
         end

         assign powered[i]   = (state[i] == PS_ON) || (state[i] == PS_EN);
         assign enabled[i]   = (state[i] == PS_EN);
         assign off_by_oc[i] = (state[i] == PS_OC);

         // switch enable pin at the configured level, off during reset
         always_ff @(posedge clock_i or posedge reset_i)
         begin
            if (reset_i)
            begin
               port_power_enable_n_o[i] <= 1'b1;
               port_enabled_o[i]        <= 1'b0;
            end
            else
            begin
               port_power_enable_n_o[i] <= powered[i] ~^ cfg.pwr_hi;
               port_enabled_o[i]        <= enabled[i];
            end
         end

         // automatic colours come from the port state and transmit level, never blinking
         hpi_lamp u_lamp (
            .clock_i      (clock_i),
            .reset_i      (reset_i),
            .code_i       (ind_code[i*IND_CODE_W +: IND_CODE_W]),
            .auto_green_i (enabled[i] || (powered[i] && port_transmit_i[i])),
            .auto_amber_i (off_by_oc[i]),
            .blink_i      (blink),
            .mod_phase_i  (mod_div[MOD_DIV_W-1]),
            .cfg_i        (cfg),
            .green_o      (led_green_o[i]),
            .amber_o      (led_amber_o[i])
         );
      end
   endgenerate

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (reset_i);

   sequence s_trip0;
      trip_eff[0] && (state[0] == PS_ON || state[0] == PS_EN);
   endsequence
   sequence s_cut0;
      ##1 (state[0] == PS_OC) ##1 (port_power_enable_n_o[0] != cfg.pwr_hi);
   endsequence
   property p_trip_cuts;
      s_trip0 |-> s_cut0;
   endproperty
   a_trip_cuts: assert property (p_trip_cuts)
      else $error("overcurrent did not remove port power");

   property p_gang_trip;
      cfg.ganged && filt[0] && powered[NUM_PORTS-1] |=> (state[NUM_PORTS-1] == PS_OC);
   endproperty
   a_gang_trip: assert property (p_gang_trip)
      else $error("ganged trip left a port powered");

   property p_unconfigured_off;
      !hub_configured_i && (state[1] == PS_OFF) |=> (state[1] == PS_OFF);
   endproperty
   a_unconfigured_off: assert property (p_unconfigured_off)
      else $error("port powered before configuration");

   property p_set_wins;
      wr_status && bus_i.wdata[0] && filt[0] |=> oc_event[0];
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("overcurrent event lost against clear");

   property p_reset_done;
      (state[0] == PS_ON) && port_reset_done_i[0] && port_connected_i[0] &&
      !trip_eff[0] && !pwr_off_req[0] |=> ##1 port_enabled_o[0];
   endproperty
   a_reset_done: assert property (p_reset_done)
      else $error("port not enabled after reset done");

   property p_read_status;
      bus_i.rd && (bus_i.addr == OFS_STATUS) |=>
         rdata_o[NUM_PORTS-1:0] == $past(oc_event);
   endproperty
   a_read_status: assert property (p_read_status)
      else $error("status read returned wrong events");

   property p_idle_read_zero;
      !bus_i.rd |=> (rdata_o == '0);
   endproperty
   a_idle_read_zero: assert property (p_idle_read_zero)
      else $error("read data outside the answer cycle");

   property p_gang_together;
      cfg.ganged && pwr_on_req[0] && !pwr_off_req[0] && !(|filt) &&
      (state[3] == PS_OFF) |=> (state[3] == PS_ON);
   endproperty
   a_gang_together: assert property (p_gang_together)
      else $error("ganged power request missed a port");

endmodule : hpi_port_power
`default_nettype wire

// >>> sim/hpi_switch_model.sv
// hpi_switch_model: external four-port power switch seen by the hub.
// assumes enables and flags active low, flag lines pulled up when idle.
`timescale 1ns/1ps
`default_nettype none
module hpi_switch_model
   import hpi_pkg::*;
(
   input  wire logic [NUM_PORTS-1:0] power_enable_n_i,
   input  wire logic [NUM_PORTS-1:0] fault_i,
   output var  logic [NUM_PORTS-1:0] overcurrent_sense_n_o
);
   // a real switch only flags while its output is on; the pull-up wins otherwise
   always_comb
   begin
      overcurrent_sense_n_o = ~(fault_i & ~power_enable_n_i);
   end
endmodule : hpi_switch_model
`default_nettype wire

// >>> sim/tb_top.sv
// tb_top: directed checks of the port power and indicator block.
// assumes the switch model as far side and MS_CYCLES shortened to 20.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin \
   mismatches++; $display("BAD %s exp %h got %h", nm, exp, got); end end
module tb_top;
   import hpi_pkg::*;
   localparam int MSC = 20;
   logic                 clock_i = 1'b0;
   logic                 reset_i = 1'b1;
   hpi_bus_type          bus = '0;
   logic [31:0]          rdata;
   logic                 configured = 1'b0;
   logic [NUM_PORTS-1:0] connected = '0;
   logic [NUM_PORTS-1:0] rst_done = '0;
   logic [NUM_PORTS-1:0] fault = '0;
   logic [NUM_PORTS-1:0] sense_n;
   logic [NUM_PORTS-1:0] port_power_enable_n;
   logic [NUM_PORTS-1:0] enabled;
   logic                 oc_rep;
   logic                 ind_bit;
   logic [NUM_PORTS-1:0] green;
   logic [NUM_PORTS-1:0] amber;
   int                   mismatches = 0;
   int                   n_checks = 0;
   int                   nhi;

   always #12.5 clock_i = ~clock_i;

   hpi_port_power #(.MS_CYCLES(MSC)) dut (
      .clock_i(clock_i), .reset_i(reset_i), .bus_i(bus), .rdata_o(rdata),
      .hub_configured_i(configured), .port_connected_i(connected),
      .port_reset_done_i(rst_done), .port_disable_i(4'h0), .port_transmit_i(4'h0),
      .port_overcurrent_sense_n_i(sense_n), .port_power_enable_n_o(port_power_enable_n),
      .port_enabled_o(enabled), .oc_report_o(oc_rep),
      .hub_char_indicator_o(ind_bit), .led_green_o(green), .led_amber_o(amber));

   hpi_switch_model sw (
      .power_enable_n_i(port_power_enable_n), .fault_i(fault), .overcurrent_sense_n_o(sense_n));

   // one-cycle write strobe; the trailing step keeps a following strobe
   // from being assigned in the same time step as this release
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge clock_i);
      bus <= '0;
      #1;
   endtask : wr

   // one-cycle read strobe; data looked at in the single cycle it stands
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      bus <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge clock_i);
      bus <= '0;
      #1 `CHK("rdata", exp, rdata)
   endtask : rd

   task automatic cyc(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask : cyc

   task automatic end_sim;
      if (mismatches == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_sim

   // watchdog well beyond the few hundred cycles the tests need
   initial
   begin
      repeat (20000) @(posedge clock_i);
      mismatches++;
      end_sim();
   end

   initial
   begin
      repeat (6) @(posedge clock_i);
      reset_i <= 1'b0;
      cyc(1);
      `CHK("pwr_rst", 4'hf, port_power_enable_n)
      `CHK("lamps_rst", 8'hff, {green, amber})
      `CHK("ind_bit_rst", 1'b1, ind_bit)
      @(posedge clock_i);
      rd(OFS_CONFIG, 32'h10);
      rd(OFS_OC_TIME, 32'h88);
      rd(8'h20, 32'h0);
      // power-on before enumeration must be ignored
      wr(OFS_POWER, 32'h3);
      cyc(4);
      `CHK("pwr_unconf", 4'hf, port_power_enable_n)
      configured <= 1'b1;
      @(posedge clock_i);
      wr(OFS_POWER, 32'h3);
      cyc(3);
      `CHK("pwr_per_port", 4'hc, port_power_enable_n)
      // port 1 fault with the default 8 ms filter, port disabled
      fault <= 4'h2;
      cyc(6 * MSC);
      `CHK("pwr_filtering", 4'hc, port_power_enable_n)
      fault <= 4'h0;
      cyc(2);
      fault <= 4'h2;
      cyc(6 * MSC);
      `CHK("pwr_restart", 4'hc, port_power_enable_n)
      cyc(3 * MSC + 4);
      `CHK("pwr_tripped", 4'he, port_power_enable_n)
      `CHK("oc_report", 1'b1, oc_rep)
      `CHK("amber_oc", 4'hd, amber)
      fault <= 4'h0;
      // port 0 reset completes while connected
      connected <= 4'h1;
      rst_done <= 4'h1;
      @(posedge clock_i);
      rst_done <= 4'h0;
      cyc(3);
      `CHK("enabled", 4'h1, enabled)
      `CHK("green_auto", 4'he, green)
      // zero filter for enabled ports trips at once
      wr(OFS_OC_TIME, 32'h80);
      fault <= 4'h1;
      cyc(6);
      fault <= 4'h0;
      `CHK("pwr_fast_trip", 4'hf, port_power_enable_n)
      `CHK("green_gone", 4'hf, green)
      cyc(4);
      rd(OFS_STATUS, 32'h3);
      wr(OFS_STATUS, 32'hf);
      rd(OFS_STATUS, 32'h0);
      // manual codes on port 2: amber, green, off
      wr(OFS_IND, {23'h0, IND_AMBER, 6'h0});
      cyc(3);
      `CHK("man_amber", 2'b10, {green[2], amber[2]})
      wr(OFS_IND, {23'h0, IND_GREEN, 6'h0});
      cyc(3);
      `CHK("man_green", 2'b01, {green[2], amber[2]})
      wr(OFS_IND, {23'h0, IND_OFF, 6'h0});
      cyc(3);
      `CHK("man_off", 2'b11, {green[2], amber[2]})
      // reserved pair on port 1 darkens the amber its trip would light
      wr(OFS_IND, {23'h0, IND_OFF, IND_BLINK_GA, 3'h0});
      cyc(3);
      `CHK("man_reserved", 2'b11, {green[1], amber[1]})
      // ganged: one set bit powers every port
      wr(OFS_CONFIG, 32'h11);
      wr(OFS_POWER, 32'h4);
      cyc(3);
      `CHK("pwr_ganged", 4'h0, port_power_enable_n)
      // ganged: a zero-length trip on port 0 cuts every port
      wr(OFS_OC_TIME, 32'h0);
      fault <= 4'h1;
      cyc(6);
      fault <= 4'h0;
      `CHK("pwr_gang_trip", 4'hf, port_power_enable_n)
      `CHK("amber_gang", 4'h6, amber)
      // lamps active high, then square-wave modulated
      wr(OFS_CONFIG, 32'h18);
      cyc(3);
      `CHK("led_hi", 8'h09, {green, amber})
      wr(OFS_CONFIG, 32'h38);
      nhi = 0;
      repeat (8)
      begin
         @(posedge clock_i);
         #1 nhi += amber[0];
      end
      `CHK("mod_duty", 4, nhi)
      // enable and sense active high: the idle pull-ups now read as faults
      wr(OFS_CONFIG, 32'h16);
      cyc(3);
      `CHK("pwr_hi", 4'h0, port_power_enable_n)
      rd(OFS_STATUS, 32'hff);
      wr(OFS_CONFIG, 32'h01);
      cyc(3);
      `CHK("ind_bit_clr", 1'b0, ind_bit)
      end_sim();
   end
endmodule : tb_top
`default_nettype wire
